// ### logic/irs_pkg.sv
`default_nettype none

package irs_pkg;

  // clock and link rates
  localparam int unsigned CLK_HZ          = 125_000_000;
  localparam int unsigned IR_BAUD         = 9600;
  localparam int unsigned BITCLKS_PER_BIT = 16;
  localparam int unsigned BITCLK_DIV      = CLK_HZ / (IR_BAUD * BITCLKS_PER_BIT);
  localparam logic [9:0]  BITCLK_LAST     = 10'(BITCLK_DIV - 1);
  localparam logic [3:0]  BITCLK_WRAP     = 4'(BITCLKS_PER_BIT - 1);

  // long timeouts, in seconds and in cycles
  localparam int unsigned IDLE_TIMEOUT_S   = 10;
  localparam logic [31:0] IDLE_TIMEOUT_CYC = 32'(CLK_HZ * IDLE_TIMEOUT_S);
  localparam int unsigned RTS_TIMEOUT_S    = 3;
  localparam logic [31:0] RTS_TIMEOUT_CYC  = 32'(CLK_HZ * RTS_TIMEOUT_S);

  // turnaround after a received byte, in bit clocks
  localparam logic [4:0]  TURN_BITCLKS = 5'(BITCLKS_PER_BIT);

  // buffers and flow control
  localparam int unsigned IR_BUF_DEPTH   = 64;
  localparam int unsigned HOST_BUF_DEPTH = 29;
  localparam logic [6:0]  IR_BUF_FULL    = 7'(IR_BUF_DEPTH);
  localparam logic [5:0]  IR_PTR_LAST    = 6'(IR_BUF_DEPTH - 1);
  localparam logic [5:0]  HOST_BUF_FULL  = 6'(HOST_BUF_DEPTH);
  localparam logic [4:0]  HOST_PTR_LAST  = 5'(HOST_BUF_DEPTH - 1);
  localparam logic [5:0]  CTS_LEVEL      = 6'd23;
  localparam logic [5:0]  CTS_SLACK      = 6'd6;
  localparam logic [6:0]  PKT_OVERHEAD   = 7'd8;
  localparam logic [6:0]  MIN_FRAME      = 7'd6;

  // identification string, last two characters are the revision
  localparam int unsigned ID_LEN   = 10;
  localparam logic [63:0] ID_TEXT  = 64'h4952_5354_4143_4b20;
  localparam logic [3:0]  ID_LAST  = 4'(ID_LEN - 1);

  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } irs_beat_t;

  typedef enum logic [1:0] {
    s_low_power,
    s_idle_disconnected,
    s_connected
  } irs_pwr_state_t;

endpackage : irs_pkg

`default_nettype wire

// ### logic/irs_power_flow.sv
// Notes on behaviour
// - link closed returns to idle disconnected state
// - idle ten seconds without activity enters low power
// - low power stops oscillator, active output low
// - photo-detect crossing reference wakes the device
// - reset wakes; ten idle seconds sleep again
// - open-collector output shows protocol handler running
// - infrared link fixed at 9.6 kbaud
// - clear-to-send high at 23 buffered host bytes
// - infrared receive block fixed at 64 bytes
// - host receive block fixed at 29 bytes
// - each packet adds 8 bytes overhead
// - infrared port half duplex, never both directions
// - one bit time between receive and transmit
// - fixed identification string, revision in last two
// - clear-to-send holds host when buffer cannot accept
// - six more bytes accepted after clear-to-send
// - request-to-send high too long drops link; timer runs only while infrared receive buffer holds data
`default_nettype none

module irs_power_flow
  import irs_pkg::*;
#(
  parameter logic [31:0] IDLE_CYCLES = IDLE_TIMEOUT_CYC,
  parameter logic [31:0] RTS_CYCLES  = RTS_TIMEOUT_CYC,
  parameter logic [15:0] SILICON_REV = 16'h6131  // arbitrary value
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // photo detector pins
  input  wire logic       photo_detect_input,
  input  wire logic       photo_detect_reference,
  // infrared pins
  input  wire logic       ir_pulse_input,
  output logic            ir_pulse_output,
  // power and activity
  output logic            osc_enable,
  output logic            protocol_handler_active_o,
  output logic            protocol_handler_active_oe,
  output logic            bit_clk_en,
  output logic            baud_en,
  // protocol handler link events
  input  wire logic       link_open,
  input  wire logic       link_close,
  output logic            link_up,
  output logic            link_timeout,
  // infrared decoder bytes
  input  wire logic       ir_rx_valid,
  input  wire logic [7:0] ir_rx_data,
  input  wire logic       ir_rx_last,
  output logic            ir_short_frame,
  output logic            ir_overrun,
  // infrared encoder
  input  wire logic       ir_tx_req,
  input  wire logic       ir_tx_pulse,
  output logic            ir_tx_grant,
  // host uart receive
  input  wire logic       host_rx_valid,
  input  wire logic [7:0] host_rx_data,
  output logic            host_rx_ready,
  output logic            host_cts,
  output logic            host_overrun,
  // packet read from host buffer
  output logic            pkt_valid,
  output logic [7:0]      pkt_data,
  input  wire logic       pkt_ready,
  output logic [6:0]      pkt_len,
  // host uart transmit
  input  wire logic       host_rts_n,
  output logic            host_tx_valid,
  output logic [7:0]      host_tx_data,
  output logic            host_tx_last,
  input  wire logic       host_tx_ready,
  // identification
  input  wire logic [3:0] id_addr,
  output logic [7:0]      id_char
);

  irs_pwr_state_t state;
  logic [3:0]     sync1;
  logic [3:0]     sync2;
  logic [2:0]     prev;
  logic           pd_above;
  logic           pd_cross;
  logic           ir_edge;
  logic           rts_n_s;
  logic           activity;
  logic [31:0]    idle_cnt;
  logic [31:0]    rts_cnt;
  logic [9:0]     div_cnt;
  logic [3:0]     bclk_cnt;
  logic [4:0]     turn_cnt;
  logic           rx_busy;
  logic           rx_take;
  logic [6:0]     frame_len;

  // pin synchronisers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
    end else begin
      sync1 <= {host_rts_n, ir_pulse_input, photo_detect_reference, photo_detect_input};
      sync2 <= sync1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prev <= 3'h0;
    end else begin
      prev <= {sync2[2], pd_above, 1'b0};
    end
  end

  assign pd_above = sync2[0] && !sync2[1];
  assign pd_cross = pd_above != prev[1];
  assign ir_edge  = sync2[2] != prev[2];
  assign rts_n_s  = sync2[3];
  assign rx_take  = ir_rx_valid && !ir_tx_grant;
  assign activity = ir_edge || rx_take || pd_cross;

  // bit clock divider, 16 per bit
  always_ff @(posedge clk) begin
    if (sys_rst || state == s_low_power) begin
      div_cnt    <= 10'h000;
      bclk_cnt   <= 4'h0;
      bit_clk_en <= 1'b0;
      baud_en    <= 1'b0;
    end else begin
      bit_clk_en <= (div_cnt == BITCLK_LAST);
      baud_en    <= (div_cnt == BITCLK_LAST) && (bclk_cnt == BITCLK_WRAP);
      if (div_cnt == BITCLK_LAST) begin
        div_cnt  <= 10'h000;
        bclk_cnt <= bclk_cnt + 4'h1;
      end else begin
        div_cnt <= div_cnt + 10'h001;
      end
    end
  end

  // power and link state
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= s_idle_disconnected;
    end else begin
      case (state)
        s_low_power: begin
          if (pd_cross) begin
            state <= s_idle_disconnected;
          end
        end
        s_idle_disconnected: begin
          if (link_open) begin
            state <= s_connected;
          end else if (!activity && idle_cnt >= IDLE_CYCLES - 32'h1) begin
            state <= s_low_power;
          end
        end
        s_connected: begin
          if (link_close || link_timeout) begin
            state <= s_idle_disconnected;
          end
        end
        default: begin
          state <= s_idle_disconnected;
        end
      endcase
    end
  end

  // inactivity timer
  always_ff @(posedge clk) begin
    if (sys_rst || state != s_idle_disconnected || activity) begin
      idle_cnt <= 32'h0;
    end else begin
      idle_cnt <= idle_cnt + 32'h1;
    end
  end

  // oscillator and open-collector active flag
  assign osc_enable                 = (state != s_low_power);
  assign protocol_handler_active_o  = 1'b0;
  assign protocol_handler_active_oe = (state == s_low_power);
  assign link_up                    = (state == s_connected);

  // half duplex and turnaround
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      turn_cnt <= 5'h00;
      rx_busy  <= 1'b0;
    end else begin
      if (rx_take) begin
        turn_cnt <= TURN_BITCLKS;
        rx_busy  <= !ir_rx_last;
      end else if (bit_clk_en && turn_cnt != 5'h00) begin
        turn_cnt <= turn_cnt - 5'h01;
      end
    end
  end

  assign ir_tx_grant = ir_tx_req && !rx_busy && turn_cnt == 5'h00 && state != s_low_power;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ir_pulse_output <= 1'b0;
    end else begin
      ir_pulse_output <= ir_tx_pulse && ir_tx_grant;
    end
  end

  // infrared receive buffer, 64 bytes
  irs_beat_t  ir_mem [IR_BUF_DEPTH];
  logic [5:0] ir_wr;
  logic [5:0] ir_rd;
  logic [6:0] ir_cnt;
  logic       ir_push;
  logic       ir_pop;
  logic       sk_in_ready;
  logic       sk_out_valid;
  irs_beat_t  sk_out;

  assign ir_push = rx_take && ir_cnt != IR_BUF_FULL;
  assign ir_pop  = ir_cnt != 7'h00 && !rts_n_s && sk_in_ready;

  always_ff @(posedge clk) begin
    if (ir_push) begin
      ir_mem[ir_wr] <= '{data: ir_rx_data, last: ir_rx_last};
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || link_timeout) begin
      ir_wr  <= 6'h00;
      ir_rd  <= 6'h00;
      ir_cnt <= 7'h00;
    end else begin
      if (ir_push) begin
        ir_wr <= (ir_wr == IR_PTR_LAST) ? 6'h00 : ir_wr + 6'h01;
      end
      if (ir_pop) begin
        ir_rd <= (ir_rd == IR_PTR_LAST) ? 6'h00 : ir_rd + 6'h01;
      end
      ir_cnt <= ir_cnt + {6'h00, ir_push} - {6'h00, ir_pop};
    end
  end

  // frame length and error flags
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      frame_len      <= 7'h00;
      ir_short_frame <= 1'b0;
      ir_overrun     <= 1'b0;
    end else begin
      ir_short_frame <= 1'b0;
      if (rx_take) begin
        frame_len <= ir_rx_last ? 7'h00 : frame_len + 7'h01;
        ir_short_frame <= ir_rx_last && (frame_len + 7'h01 < MIN_FRAME);
        if (ir_cnt == IR_BUF_FULL) begin
          ir_overrun <= 1'b1;
        end
      end
    end
  end

  // two-entry buffer toward host uart transmitter
  irs_skid u_skid (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (ir_pop),
    .in_beat   (ir_mem[ir_rd]),
    .in_ready  (sk_in_ready),
    .out_valid (sk_out_valid),
    .out_beat  (sk_out),
    .out_ready (host_tx_ready)
  );

  assign host_tx_valid = sk_out_valid;
  assign host_tx_data  = sk_out.data;
  assign host_tx_last  = sk_out.last;

  // request-to-send hold-off timeout
  always_ff @(posedge clk) begin
    if (sys_rst || state != s_connected || rts_n_s == 1'b0 || ir_cnt == 7'h00) begin
      rts_cnt      <= 32'h0;
      link_timeout <= 1'b0;
    end else begin
      rts_cnt      <= rts_cnt + 32'h1;
      link_timeout <= (rts_cnt == RTS_CYCLES - 32'h1);
    end
  end

  // host uart receive buffer, 29 bytes
  logic [7:0] host_mem [HOST_BUF_DEPTH];
  logic [4:0] host_wr;
  logic [4:0] host_rd;
  logic [5:0] host_cnt;
  logic       host_push;
  logic       host_pop;

  assign host_rx_ready = host_cnt != HOST_BUF_FULL;
  assign host_push     = host_rx_valid && host_rx_ready;
  assign host_pop      = pkt_valid && pkt_ready;
  assign pkt_valid     = host_cnt != 6'h00;
  assign pkt_data      = host_mem[host_rd];

  always_ff @(posedge clk) begin
    if (host_push) begin
      host_mem[host_wr] <= host_rx_data;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      host_wr  <= 5'h00;
      host_rd  <= 5'h00;
      host_cnt <= 6'h00;
    end else begin
      if (host_push) begin
        host_wr <= (host_wr == HOST_PTR_LAST) ? 5'h00 : host_wr + 5'h01;
      end
      if (host_pop) begin
        host_rd <= (host_rd == HOST_PTR_LAST) ? 5'h00 : host_rd + 5'h01;
      end
      host_cnt <= host_cnt + {5'h00, host_push} - {5'h00, host_pop};
    end
  end

  // clear-to-send, high holds the host off
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      host_cts <= 1'b1;
    end else begin
      host_cts <= (state != s_connected) || (host_cnt >= CTS_LEVEL) ||
                  (host_cnt + CTS_SLACK > HOST_BUF_FULL);
    end
  end

  // host overrun, sticky until reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      host_overrun <= 1'b0;
    end else if (host_rx_valid && !host_rx_ready) begin
      host_overrun <= 1'b1;
    end
  end

  // packet length with protocol overhead
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pkt_len <= 7'h00;
    end else begin
      pkt_len <= {1'b0, host_cnt} + PKT_OVERHEAD;
    end
  end

  // identification string
  logic [79:0] id_full;

  assign id_full = {ID_TEXT, SILICON_REV};

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      id_char <= 8'h00;
    end else if (id_addr <= ID_LAST) begin
      id_char <= id_full[8'(79 - 8 * id_addr) -: 8];
    end else begin
      id_char <= 8'h00;
    end
  end

endmodule : irs_power_flow

`default_nettype wire

// ### logic/irs_skid.sv
`default_nettype none

module irs_skid
  import irs_pkg::*;
(
  // clock and reset
  input  wire logic      clk,
  input  wire logic      sys_rst,
  // filling side
  input  wire logic      in_valid,
  input  wire irs_beat_t in_beat,
  output logic           in_ready,
  // draining side
  output logic           out_valid,
  output irs_beat_t      out_beat,
  input  wire logic      out_ready
);

  irs_beat_t  ent1;
  logic [1:0] cnt;
  logic       push;
  logic       pop;

  assign in_ready  = (cnt != 2'h2);
  assign out_valid = (cnt != 2'h0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // two entries, head in out_beat
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt      <= 2'h0;
      out_beat <= '0;
      ent1     <= '0;
    end else begin
      case ({push, pop})
        2'b10: begin
          if (cnt == 2'h0) begin
            out_beat <= in_beat;
          end else begin
            ent1 <= in_beat;
          end
          cnt <= cnt + 2'h1;
        end
        2'b01: begin
          out_beat <= ent1;
          cnt      <= cnt - 2'h1;
        end
        2'b11: begin
          if (cnt == 2'h1) begin
            out_beat <= in_beat;
          end else begin
            out_beat <= ent1;
            ent1     <= in_beat;
          end
        end
        default: begin
          cnt <= cnt;
        end
      endcase
    end
  end

endmodule : irs_skid

`default_nettype wire

// ### test/irs_host_model.sv
`default_nettype none

module irs_host_model
  import irs_pkg::*;
(
  // clock and bench controls
  input  wire logic       clk,
  input  wire logic       send_en,
  input  wire logic       ignore_cts,
  input  wire logic       stall,
  // host uart lines
  input  wire logic       host_rx_ready,
  input  wire logic       host_cts,
  output logic            host_rx_valid,
  output logic [7:0]      host_rx_data,
  input  wire logic       host_tx_valid,
  input  wire logic [7:0] host_tx_data,
  output logic            host_tx_ready,
  // results
  output int              n_sent,
  output int              n_got,
  output logic [7:0]      last_rx
);
  timeunit 1ns;
  timeprecision 100ps;
  logic took;

  initial begin
    {host_rx_valid, host_rx_data, host_tx_ready, last_rx} = '0;
    n_sent = 0;
    n_got = 0;
  end

  always @(posedge clk) begin
    took = host_rx_valid && host_rx_ready;
    if (host_tx_valid && host_tx_ready) begin
      last_rx = host_tx_data;
      n_got++;
    end
    #1;
    if (took) begin
      n_sent++;
      host_rx_valid = 1'b0;
      host_rx_data = ~host_rx_data;
    end else if (!host_rx_valid && send_en && (ignore_cts || !host_cts)) begin
      host_rx_valid = 1'b1;
      host_rx_data = n_sent[7:0];
    end
    host_tx_ready = !stall;
  end
endmodule : irs_host_model

`default_nettype wire

// ### test/irs_power_flow_props.sv
`default_nettype none

module irs_power_flow_props
  import irs_pkg::*;
(
  // clock and reset
  input wire logic       clk,
  input wire logic       sys_rst,
  // power
  input wire logic       photo_detect_input,
  input wire logic       photo_detect_reference,
  input wire logic       osc_enable,
  input wire logic       protocol_handler_active_o,
  input wire logic       protocol_handler_active_oe,
  input wire logic       bit_clk_en,
  // link
  input wire logic       link_close,
  input wire logic       link_up,
  input wire logic       ir_rx_valid,
  input wire logic       ir_tx_grant,
  // host side
  input wire logic       host_rx_valid,
  input wire logic       host_rx_ready,
  input wire logic       host_cts,
  input wire logic       host_overrun,
  input wire logic [6:0] pkt_len
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  logic [9:0] gap;
  logic       seen;

  // cycles since the last bit clock
  always_ff @(posedge clk) begin
    if (sys_rst || !osc_enable) begin
      gap  <= '0;
      seen <= 1'b0;
    end else if (bit_clk_en) begin
      gap  <= '0;
      seen <= 1'b1;
    end else begin
      gap <= gap + 10'h001;
    end
  end

  chk_bit_rate: assert property (bit_clk_en && seen |-> gap == BITCLK_LAST)
    else $error("bit clock spacing wrong");
  chk_sleep_state: assert property (!osc_enable |-> protocol_handler_active_oe && !link_up && !bit_clk_en)
    else $error("low power outputs wrong");
  chk_active_low: assert property (protocol_handler_active_oe |-> !protocol_handler_active_o)
    else $error("open collector drives high");
  chk_photo_wake: assert property (!osc_enable && $changed(photo_detect_input && !photo_detect_reference)
    |-> ##[1:5] osc_enable)
    else $error("no wake on photo crossing");
  chk_close_idle: assert property (link_close && link_up |=> !link_up)
    else $error("link stays up after close");
  chk_cts_level: assert property (host_cts == (!$past(link_up) || pkt_len >= 7'(CTS_LEVEL) + PKT_OVERHEAD))
    else $error("clear to send level wrong");
  chk_host_refuse: assert property (host_rx_valid && !host_rx_ready |=> host_overrun)
    else $error("refused byte not flagged");
  chk_turn_gap: assert property (ir_rx_valid && !ir_tx_grant |=> !ir_tx_grant [*8])
    else $error("grant too soon after receive");
endmodule : irs_power_flow_props

bind irs_power_flow irs_power_flow_props i_props (
  .clk, .sys_rst, .photo_detect_input, .photo_detect_reference, .osc_enable,
  .protocol_handler_active_o, .protocol_handler_active_oe, .bit_clk_en, .link_close,
  .link_up, .ir_rx_valid, .ir_tx_grant, .host_rx_valid, .host_rx_ready, .host_cts,
  .host_overrun, .pkt_len
);

`default_nettype wire

// ### test/irs_power_flow_tb.sv
`default_nettype none

module irs_power_flow_tb
  import irs_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;

  logic clk = 1'b0, sys_rst = 1'b1;
  logic photo_detect_input, photo_detect_reference, ir_pulse_input, ir_tx_req, ir_tx_pulse;
  logic link_open, link_close, ir_rx_valid, ir_rx_last, pkt_ready, host_rts_n;
  logic send_en, ignore_cts, stall, saw_short;
  logic [7:0] ir_rx_data;
  logic [3:0] id_addr;
  logic osc_enable, protocol_handler_active_o, protocol_handler_active_oe, bit_clk_en, ir_pulse_output;
  logic link_up, link_timeout, ir_short_frame, ir_tx_grant, host_rx_valid, host_rx_ready, host_cts;
  logic host_overrun, pkt_valid, host_tx_valid, host_tx_ready;
  logic [7:0] host_rx_data, pkt_data, host_tx_data, id_char, last_rx;
  logic [6:0] pkt_len;
  int n_sent, n_got, bad_count = 0, n_compared = 0;

  irs_power_flow #(.IDLE_CYCLES(32'd200), .RTS_CYCLES(32'd100), .SILICON_REV(16'h6131)) i_irs_power_flow (
    .clk, .sys_rst, .photo_detect_input, .photo_detect_reference, .ir_pulse_input, .ir_pulse_output,
    .osc_enable, .protocol_handler_active_o, .protocol_handler_active_oe, .bit_clk_en, .baud_en(),
    .link_open, .link_close, .link_up, .link_timeout, .ir_rx_valid, .ir_rx_data, .ir_rx_last,
    .ir_short_frame, .ir_overrun(), .ir_tx_req, .ir_tx_pulse, .ir_tx_grant, .host_rx_valid,
    .host_rx_data, .host_rx_ready, .host_cts, .host_overrun, .pkt_valid, .pkt_data, .pkt_ready,
    .pkt_len, .host_rts_n, .host_tx_valid, .host_tx_data, .host_tx_last(), .host_tx_ready,
    .id_addr, .id_char
  );

  irs_host_model i_irs_host_model (
    .clk, .send_en, .ignore_cts, .stall, .host_rx_ready, .host_cts, .host_rx_valid, .host_rx_data,
    .host_tx_valid, .host_tx_data, .host_tx_ready, .n_sent, .n_got, .last_rx
  );

  always #4 clk = ~clk;

  always @(posedge clk) begin
    if (ir_short_frame === 1'b1) saw_short <= 1'b1;
  end

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic need(input logic ok);
    chk(48'(ok), 48'h1);
    if (ok !== 1'b1) give_verdict();
  endtask : need

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic pulse_open();
    link_open = 1'b1;
    tick(1);
    link_open = 1'b0;
  endtask : pulse_open

  task automatic ir_byte(input logic [7:0] d, input logic l);
    {ir_rx_valid, ir_rx_data, ir_rx_last} = {1'b1, d, l};
    tick(1);
    ir_rx_valid = 1'b0;
    tick(1);
  endtask : ir_byte

  task automatic t_power();
    int k;
    chk({osc_enable, protocol_handler_active_oe, protocol_handler_active_o, host_cts, link_up}, 5'b10010);
    tick(150);
    ir_pulse_input = 1'b1;
    tick(150);
    chk(osc_enable, 1'b1);
    for (k = 0; k < 80 && osc_enable; k++) tick(1);
    need(!osc_enable);
    chk({protocol_handler_active_oe, protocol_handler_active_o}, 2'b10);
    photo_detect_input = 1'b1;
    for (k = 0; k < 6 && !osc_enable; k++) tick(1);
    need(osc_enable);
    for (k = 0; k < 260 && osc_enable; k++) tick(1);
    need(!osc_enable);
    sys_rst = 1'b1;
    tick(2);
    sys_rst = 1'b0;
    chk(osc_enable, 1'b1);
    $display("t_power done");
  endtask : t_power

  task automatic t_host();
    pulse_open();
    send_en = 1'b1;
    tick(80);
    chk({n_sent, host_cts, pkt_len}, {32'd23, 1'b1, 7'd31});
    ignore_cts = 1'b1;
    tick(40);
    chk({n_sent, host_rx_ready, host_overrun}, {32'd29, 1'b0, 1'b1});
    send_en = 1'b0;
    pkt_ready = 1'b1;
    for (int k = 0; k < 30; k++) begin
      need(pkt_valid);
      chk(pkt_data, 8'(k));
      tick(1);
    end
    {pkt_ready, ignore_cts} = 2'b00;
    tick(1);
    chk({pkt_valid, host_cts}, 2'b00);
    link_close = 1'b1;
    tick(1);
    link_close = 1'b0;
    tick(1);
    chk({link_up, host_cts}, 2'b01);
    $display("t_host done");
  endtask : t_host

  task automatic t_ir();
    int k;
    pulse_open();
    stall = 1'b1;
    for (k = 0; k < 5; k++) ir_byte(8'ha0 + 8'(k), k == 4);
    ir_tx_req = 1'b1;
    chk({saw_short, ir_tx_grant}, 2'b10);
    for (k = 0; k < 20000 && !ir_tx_grant; k++) tick(1);
    need(ir_tx_grant);
    chk(48'(k > 15 * BITCLK_DIV), 48'h1);
    ir_tx_pulse = 1'b1;
    tick(1);
    chk(ir_pulse_output, 1'b1);
    {ir_tx_pulse, ir_tx_req, stall} = 3'b000;
    tick(30);
    chk({n_got, last_rx}, {32'd5, 8'ha4});
    host_rts_n = 1'b1;
    tick(3);
    ir_byte(8'h55, 1'b1);
    for (k = 0; k < 300 && !link_timeout; k++) tick(1);
    need(link_timeout);
    tick(1);
    chk(link_up, 1'b0);
    host_rts_n = 1'b0;
    $display("t_ir done");
  endtask : t_ir

  task automatic t_id();
    logic [79:0] txt;
    txt = {ID_TEXT, 16'h6131};
    for (int a = 0; a < 11; a++) begin
      id_addr = 4'(a);
      tick(1);
      chk(id_char, a < 10 ? txt[79 - 8 * a -: 8] : 8'h00);
    end
    $display("t_id done");
  endtask : t_id

  initial begin
    {photo_detect_input, photo_detect_reference, ir_pulse_input, ir_tx_req, ir_tx_pulse} = '0;
    {link_open, link_close, ir_rx_valid, ir_rx_last, pkt_ready, host_rts_n, ir_rx_data, id_addr} = '0;
    {send_en, ignore_cts, stall, saw_short} = '0;
    tick(2);
    sys_rst = 1'b0;
    t_power();
    t_host();
    t_ir();
    t_id();
    give_verdict();
  end
endmodule : irs_power_flow_tb

`default_nettype wire
